// file: fixcode_pkg.sv
// Constants shared by the fixed-code write command handler
// Contract
// - Frame bytes 0-7 hold control, 1Fh, type, length
// - Data from byte 8, count equals length field
// - Response echoes control, 1Fh, status, reply counter
// - Response bytes 6-7 return length, high first
// - Exactly one write attempt, no retry
// - Type 30h 32h writes a permanent code
// - Type 31h 31h writes an overwritable code
// - Second family needs length 7, type 35h 32h
// - Compatible code occupies first 8 tag bytes
// - Type 50 read returns native 4-byte code
// - No read-back verification after the write
package fixcode_pkg;
	// Register byte offsets
	localparam logic [5:0] ADR_CTRL = 6'h00;
	localparam logic [5:0] ADR_STAT = 6'h04;
	localparam logic [5:0] ADR_TTYPE = 6'h08;
	localparam logic [5:0] ADR_FIXRD = 6'h0C;
	localparam logic [5:0] ADR_CMD0 = 6'h10;
	localparam logic [5:0] ADR_CMD3 = 6'h1C;
	localparam logic [5:0] ADR_RSP0 = 6'h20;
	localparam logic [5:0] ADR_RSP1 = 6'h24;
	// Control and status bit positions
	localparam int CTRL_START = 0;
	localparam int CTRL_CLR = 1;
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_CODE = 8;
	// Frame layout
	localparam logic [7:0] CMD_CODE = 8'h1F;
	localparam int FRM_BYTES = 16;
	localparam int DATA_BASE = 8;
	localparam int MAX_DATA = 8;
	localparam logic [15:0] LEN_MIN = 16'h0001;
	localparam logic [15:0] LEN_MAX = 16'h0008;
	// Code types and lengths per family
	localparam logic [15:0] TYPE_LOCK = 16'h3032;
	localparam logic [15:0] TYPE_REWR = 16'h3131;
	localparam logic [15:0] TYPE_COMPAT = 16'h3532;
	localparam logic [15:0] TTYPE_50 = 16'h3530;
	localparam logic [15:0] FAM1_LEN = 16'h0005;
	localparam logic [15:0] FAM2_LEN = 16'h0007;
	localparam int FAM2_HEX = 3;
	localparam logic [3:0] COMPAT_SPAN = 4'h8;
	// Reset values
	localparam logic [15:0] TTYPE_RST = 16'h0000;
	localparam logic [7:0] RCNT_RST = 8'h00;
	// Status codes
	localparam logic [7:0] ST_OK = 8'h00;
	localparam logic [7:0] ST_BAD_FRAME = 8'h01;
	localparam logic [7:0] ST_BAD_TYPE = 8'h02;
	localparam logic [7:0] ST_BAD_DATA = 8'h03;
	localparam logic [7:0] ST_NO_SELECT = 8'h04;
	localparam logic [7:0] ST_WR_FAIL = 8'h05;
endpackage

// file: frame_if.sv
// Interface between the frame store and the frame checker
`timescale 1ns/10ps
interface frame_if;
	logic [15:0][7:0] frame;
	logic [15:0] tag_type;
	logic [7:0] status;
	logic ok;
	logic lock;
	logic compat;
	logic [3:0] span;
	modport store (output frame, output tag_type,
		input status, input ok, input lock, input compat, input span);
	modport check (input frame, input tag_type,
		output status, output ok, output lock, output compat, output span);
endinterface

// file: fixcode_check.sv
// Combinational checker of a fixed-code write command frame
`timescale 1ns/10ps
module fixcode_check (
	frame_if.check f
);
	logic [15:0] ftype;
	logic [15:0] flen;
	logic chars_ok;

	always_comb begin
		logic [7:0] c;
		c = 8'h00;
		ftype = {f.frame[4], f.frame[5]};
		flen = {f.frame[6], f.frame[7]};
		chars_ok = 1'b1;
		for (int i = 0; i < 7; i++) begin
			c = f.frame[fixcode_pkg::DATA_BASE + i];
			if (!(c >= 8'h30 && c <= 8'h39) &&
				!(i < fixcode_pkg::FAM2_HEX && c >= 8'h41 && c <= 8'h46)) begin
				chars_ok = 1'b0;
			end
		end
		f.status = fixcode_pkg::ST_OK;
		f.lock = 1'b0;
		f.compat = 1'b0;
		f.span = flen[3:0];
		if (f.frame[2] != fixcode_pkg::CMD_CODE || f.frame[1] != 8'h00 ||
			f.frame[3] != 8'h00) begin
			f.status = fixcode_pkg::ST_BAD_FRAME;
		end else if (flen < fixcode_pkg::LEN_MIN || flen > fixcode_pkg::LEN_MAX) begin
			f.status = fixcode_pkg::ST_BAD_FRAME;
		end else if (ftype == fixcode_pkg::TYPE_LOCK || ftype == fixcode_pkg::TYPE_REWR) begin
			f.lock = (ftype == fixcode_pkg::TYPE_LOCK);
			if (flen != fixcode_pkg::FAM1_LEN) begin
				f.status = fixcode_pkg::ST_BAD_TYPE;
			end
		end else if (ftype == fixcode_pkg::TYPE_COMPAT) begin
			f.compat = 1'b1;
			f.span = fixcode_pkg::COMPAT_SPAN;
			if (flen != fixcode_pkg::FAM2_LEN) begin
				f.status = fixcode_pkg::ST_BAD_TYPE;
			end else if (!chars_ok) begin
				f.status = fixcode_pkg::ST_BAD_DATA;
			end else if (f.tag_type != fixcode_pkg::TTYPE_50) begin
				f.status = fixcode_pkg::ST_NO_SELECT;
			end
		end else begin
			f.status = fixcode_pkg::ST_BAD_TYPE;
		end
		f.ok = (f.status == fixcode_pkg::ST_OK);
	end
endmodule // fixcode_check

// file: fixcode_cmd.sv
// Fixed-code single write command handler with Wishbone registers
`timescale 1ns/10ps
module fixcode_cmd (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Read/write head
	output logic tag_wr_req_o,
	output logic [63:0] tag_code_o,
	output logic [3:0] tag_span_o,
	output logic tag_lock_o,
	output logic tag_compat_o,
	input wire logic tag_wr_done_i,
	input wire logic tag_wr_ok_i,
	input wire logic [31:0] tag_native_code_i,
	input wire logic [31:0] tag_compat_code_i
);
	typedef enum logic [1:0] {S_IDLE, S_CHECK, S_WRITE, S_RESP} st_t;

	typedef struct packed {
		st_t st;
		logic ack;
		logic [31:0] dat;
		logic [15:0][7:0] frame;
		logic [7:0][7:0] resp;
		logic [7:0] rcnt;
		logic [15:0] ttype;
		logic done;
		logic [7:0] stat;
		logic req;
		logic [7:0][7:0] code;
		logic [3:0] span;
		logic lock;
		logic compat;
	} state_t;

	state_t r;
	state_t n;
	frame_if fi ();

	assign fi.frame = r.frame;
	assign fi.tag_type = r.ttype;

	fixcode_check u_check (
		.f(fi.check)
	);

	logic access;
	logic wr;
	logic [31:0] rd;
	logic [1:0] widx;

	assign access = wb_cyc_i && wb_stb_i && !r.ack;
	assign wr = access && wb_we_i;
	assign widx = wb_adr_i[3:2];

	// Read mux; unmapped offsets read zero
	always_comb begin
		rd = 32'h0000_0000;
		case (wb_adr_i)
			fixcode_pkg::ADR_STAT: begin
				rd[fixcode_pkg::STAT_BUSY] = (r.st != S_IDLE);
				rd[fixcode_pkg::STAT_DONE] = r.done;
				rd[fixcode_pkg::STAT_CODE +: 8] = r.stat;
			end
			fixcode_pkg::ADR_TTYPE: begin
				rd[15:0] = r.ttype;
			end
			fixcode_pkg::ADR_FIXRD: begin
				if (r.ttype == fixcode_pkg::TTYPE_50) begin
					rd = tag_native_code_i;
				end else begin
					rd = tag_compat_code_i;
				end
			end
			fixcode_pkg::ADR_RSP0: begin
				rd = r.resp[3:0];
			end
			fixcode_pkg::ADR_RSP1: begin
				rd = r.resp[7:4];
			end
			default: begin
				if (wb_adr_i >= fixcode_pkg::ADR_CMD0 && wb_adr_i <= fixcode_pkg::ADR_CMD3) begin
					rd = r.frame[widx * 4 +: 4];
				end
			end
		endcase
	end

	always_comb begin
		n = r;
		n.ack = access;
		if (access && !wb_we_i) begin
			n.dat = rd;
		end
		// Frame is frozen while a command runs, so the checked copy stays valid
		if (wr && r.st == S_IDLE && wb_adr_i >= fixcode_pkg::ADR_CMD0 &&
			wb_adr_i <= fixcode_pkg::ADR_CMD3) begin
			for (int b = 0; b < 4; b++) begin
				if (wb_sel_i[b]) begin
					n.frame[widx * 4 + b] = wb_dat_i[8 * b +: 8];
				end
			end
		end
		if (wr && wb_adr_i == fixcode_pkg::ADR_TTYPE && r.st == S_IDLE) begin
			if (wb_sel_i[0]) begin
				n.ttype[7:0] = wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				n.ttype[15:8] = wb_dat_i[15:8];
			end
		end
		if (wr && wb_adr_i == fixcode_pkg::ADR_CTRL && wb_sel_i[0] &&
			wb_dat_i[fixcode_pkg::CTRL_CLR]) begin
			n.done = 1'b0;
		end
		case (r.st)
			S_IDLE: begin
				if (wr && wb_adr_i == fixcode_pkg::ADR_CTRL && wb_sel_i[0] &&
					wb_dat_i[fixcode_pkg::CTRL_START]) begin
					n.st = S_CHECK;
				end
			end
			S_CHECK: begin
				n.stat = fi.status;
				if (fi.ok) begin
					// Unused data bytes go out as zero
					for (int i = 0; i < fixcode_pkg::MAX_DATA; i++) begin
						n.code[i] = (i < int'(fi.span) && i < int'(r.frame[7])) ?
							r.frame[fixcode_pkg::DATA_BASE + i] : 8'h00;
					end
					n.span = fi.span;
					n.lock = fi.lock;
					n.compat = fi.compat;
					n.req = 1'b1;
					n.st = S_WRITE;
				end else begin
					n.st = S_RESP;
				end
			end
			S_WRITE: begin
				// One attempt only; result goes straight out, nothing is read back
				if (tag_wr_done_i) begin
					n.req = 1'b0;
					n.stat = tag_wr_ok_i ? fixcode_pkg::ST_OK : fixcode_pkg::ST_WR_FAIL;
					n.st = S_RESP;
				end
			end
			S_RESP: begin
				n.resp[0] = r.frame[0];
				n.resp[1] = 8'h00;
				n.resp[2] = fixcode_pkg::CMD_CODE;
				n.resp[3] = 8'h00;
				n.resp[4] = r.stat;
				n.resp[5] = r.rcnt + 8'h01;
				n.resp[6] = r.frame[6];
				n.resp[7] = r.frame[7];
				n.rcnt = r.rcnt + 8'h01;
				// Set beats a clear written in the same cycle
				n.done = 1'b1;
				n.st = S_IDLE;
			end
			default: begin
				n.st = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
			r.st <= S_IDLE;
			r.ttype <= fixcode_pkg::TTYPE_RST;
			r.rcnt <= fixcode_pkg::RCNT_RST;
			r.stat <= fixcode_pkg::ST_OK;
		end else begin
			r <= n;
		end
	end

	assign wb_ack_o = r.ack;
	assign wb_dat_o = r.dat;
	assign tag_wr_req_o = r.req;
	assign tag_code_o = r.code;
	assign tag_span_o = r.span;
	assign tag_lock_o = r.lock;
	assign tag_compat_o = r.compat;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged next cycle");
	a_bad_frame_nowrite: assert property (r.st == S_CHECK && !fi.ok |=> !tag_wr_req_o)
		else $error("write started for a rejected frame");
	a_resp_header: assert property (r.st == S_RESP |=> r.resp[2] == fixcode_pkg::CMD_CODE &&
		r.resp[1] == 8'h00 && r.resp[3] == 8'h00 && r.resp[0] == r.frame[0])
		else $error("response header wrong");
	a_resp_length: assert property (r.st == S_RESP |=>
		r.resp[6] == $past(r.frame[6]) && r.resp[7] == $past(r.frame[7]))
		else $error("response length not echoed");
	a_single_attempt: assert property (tag_wr_req_o && tag_wr_done_i |=> !tag_wr_req_o [*3])
		else $error("write attempt repeated");
	a_lock_type: assert property (tag_wr_req_o && tag_lock_o |->
		{r.frame[4], r.frame[5]} == fixcode_pkg::TYPE_LOCK)
		else $error("permanent write without locking type");
	a_compat_span: assert property (tag_wr_req_o && tag_compat_o |->
		tag_span_o == fixcode_pkg::COMPAT_SPAN && r.ttype == fixcode_pkg::TTYPE_50)
		else $error("compatible write span or selection wrong");
	a_no_verify: assert property (r.st == S_WRITE && tag_wr_done_i |=> r.st == S_RESP)
		else $error("extra step after write attempt");
	a_one_response: assert property (r.st == S_RESP |=>
		r.rcnt == $past(r.rcnt) + 8'h01 && r.done && r.st == S_IDLE)
		else $error("reply counter or done wrong");
	a_native_read: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o &&
		wb_adr_i == fixcode_pkg::ADR_FIXRD && r.ttype == fixcode_pkg::TTYPE_50 |=>
		wb_dat_o == $past(tag_native_code_i))
		else $error("native code not returned");

	c_write_ok: cover property (tag_wr_req_o && tag_wr_done_i && tag_wr_ok_i);
	c_write_fail: cover property (tag_wr_req_o && tag_wr_done_i && !tag_wr_ok_i);
	c_compat_write: cover property (tag_wr_req_o && tag_compat_o);
	c_rejected: cover property (r.st == S_CHECK && !fi.ok);
endmodule // fixcode_cmd

// file: head_model.sv
// Behavioural read/write head answering each write request once
`timescale 1ns/10ps
module head_model #(
	parameter logic [31:0] NATIVE = 32'h1357_9BDF,
	parameter logic [31:0] COMPAT = 32'h2468_ACE0
) (
	// Clock and request from the block
	input wire logic clk_i,
	input wire logic req_i,
	// Behaviour set by the bench
	input wire logic [3:0] lat_i,
	input wire logic ok_set_i,
	// Answers to the block
	output logic done_o,
	output logic ok_o,
	output logic [31:0] native_o,
	output logic [31:0] compat_o
);
	// Arbitrary tag contents
	assign native_o = NATIVE;
	assign compat_o = COMPAT;
	initial begin
		done_o = 1'b0;
		ok_o = 1'b0;
		forever begin
			@(posedge clk_i);
			if (req_i) begin
				repeat (lat_i) @(posedge clk_i);
				done_o <= 1'b1;
				ok_o <= ok_set_i;
				@(posedge clk_i);
				// Result line is meaningless outside done
				done_o <= 1'b0;
				ok_o <= ~ok_set_i;
				while (req_i) @(posedge clk_i);
			end
		end
	end
endmodule // head_model

// file: fixcode_cmd_tb.sv
// Self-checking bench for the fixed-code write command handler
`timescale 1ns/10ps
module fixcode_cmd_tb;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ok_set = 1'b1;
	logic [5:0] adr = 6'h00;
	logic [31:0] dat = 32'h0000_0000, rd, nat, cmp;
	logic [3:0] lat = 4'h1;
	logic [3:0] sel = 4'hF;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, req, lock, compat, done, okr, req_q = 1'b0;
	logic [63:0] code;
	logic [3:0] span;
	logic [63:0] rdq[$];
	logic [69:0] tagq[$];
	logic [7:0] rcnt = 8'h00;
	int bad_count = 0, n_checks = 0, seed = 92;
	fixcode_cmd DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.tag_wr_req_o(req), .tag_code_o(code), .tag_span_o(span), .tag_lock_o(lock),
		.tag_compat_o(compat), .tag_wr_done_i(done), .tag_wr_ok_i(okr),
		.tag_native_code_i(nat), .tag_compat_code_i(cmp));
	head_model head (.clk_i(clk_i), .req_i(req), .lat_i(lat), .ok_set_i(ok_set), .done_o(done),
		.ok_o(okr), .native_o(nat), .compat_o(cmp));
	initial forever #20 clk_i = ~clk_i;
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic cmp_val(input logic [69:0] got, input logic [69:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Read results: oldest note against data at the ack edge
	always @(posedge clk_i) if (wb_ack_o && !we && rdq.size() > 0) begin
		logic [63:0] n;
		n = rdq.pop_front();
		if (n[63:32] != 32'h0) cmp_val(wb_dat_o & n[63:32], n[31:0]);
	end
	// Each rising request must match one noted attempt
	always @(posedge clk_i) begin
		if (req && !req_q) begin
			if (tagq.size() == 0) cmp_val(70'h1, 70'h0);
			else cmp_val({lock, compat, span, code}, tagq.pop_front());
		end
		req_q <= req;
	end
	task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic [31:0] e);
		if (!w) rdq.push_back({m, e});
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic cmd(input logic [15:0] ty, input logic [15:0] ln, input logic [63:0] dt,
		input logic ok, input logic [7:0] st);
		logic [7:0] ctl;
		ctl = 8'($random(seed));
		ok_set = ok;
		wb(1'b1, fixcode_pkg::ADR_CMD0, {8'h00, fixcode_pkg::CMD_CODE, 8'h00, ctl}, 0, 0);
		wb(1'b1, 6'h14, {ln[7:0], ln[15:8], ty[7:0], ty[15:8]}, 0, 0);
		wb(1'b1, 6'h18, dt[31:0], 0, 0);
		wb(1'b1, fixcode_pkg::ADR_CMD3, dt[63:32], 0, 0);
		if (st == fixcode_pkg::ST_OK || st == fixcode_pkg::ST_WR_FAIL)
			tagq.push_back({ty == fixcode_pkg::TYPE_LOCK, ty == fixcode_pkg::TYPE_COMPAT,
				ty == fixcode_pkg::TYPE_COMPAT ? fixcode_pkg::COMPAT_SPAN : ln[3:0], dt});
		wb(1'b1, fixcode_pkg::ADR_CTRL, 32'h0000_0001, 0, 0);
		rd = 32'h0000_0000;
		for (int i = 0; i < 60 && !rd[1]; i++) wb(1'b0, fixcode_pkg::ADR_STAT, 0, 0, 0);
		cmp_val(70'(rd[1]), 70'h1);
		rcnt++;
		wb(1'b0, fixcode_pkg::ADR_RSP0, 0, 32'hFFFF_FFFF, {8'h00, 8'h1F, 8'h00, ctl});
		wb(1'b0, fixcode_pkg::ADR_RSP1, 0, 32'hFFFF_FFFF, {ln[7:0], ln[15:8], rcnt, st});
		wb(1'b1, fixcode_pkg::ADR_CTRL, 32'h0000_0002, 0, 0);
		wb(1'b0, fixcode_pkg::ADR_STAT, 0, 32'h0000_FF03, {16'h0000, st, 8'h00});
	endtask
	function automatic logic [63:0] f2code(input int bad);
		logic [63:0] c;
		logic [7:0] n;
		c = 64'h0;
		for (int i = 0; i < 7; i++) begin
			n = 8'($random(seed)) & (i < 3 ? 8'h0F : 8'h07);
			c[8*i +: 8] = n < 8'h0A ? 8'h30 + n : 8'h37 + n;
		end
		if (bad == 1) c[7:0] = 8'h47;
		if (bad == 2) c[55:48] = 8'h41;
		return c;
	endfunction
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, fixcode_pkg::ADR_TTYPE, 0, 32'h0000_FFFF, 32'h0000_0000);
		wb(1'b0, fixcode_pkg::ADR_RSP1, 0, 32'hFFFF_FFFF, 32'h0000_0000);
		wb(1'b1, 6'h2C, 32'hFFFF_FFFF, 0, 0);
		wb(1'b0, 6'h2C, 0, 32'hFFFF_FFFF, 32'h0000_0000);
		// Only the low byte enable is given, so the high byte must stay zero
		sel <= 4'h1;
		wb(1'b1, fixcode_pkg::ADR_TTYPE, 32'h0000_FFFF, 0, 0);
		sel <= 4'hF;
		wb(1'b0, fixcode_pkg::ADR_TTYPE, 0, 32'h0000_FFFF, 32'h0000_00FF);
		cmd(fixcode_pkg::TYPE_LOCK, 16'h0005, {24'h0, 40'($random(seed))}, 1'b1, 8'h00);
		lat = 4'h6;
		cmd(fixcode_pkg::TYPE_REWR, 16'h0005, {24'h0, 40'($random(seed))}, 1'b0, 8'h05);
		cmd(fixcode_pkg::TYPE_REWR, 16'h0007, 64'h0, 1'b1, 8'h02);
		cmd(fixcode_pkg::TYPE_LOCK, 16'h0000, 64'h0, 1'b1, 8'h01);
		cmd(fixcode_pkg::TYPE_LOCK, 16'h0009, 64'h0, 1'b1, 8'h01);
		cmd(fixcode_pkg::TYPE_COMPAT, 16'h0007, f2code(0), 1'b1, 8'h04);
		wb(1'b1, fixcode_pkg::ADR_TTYPE, 32'h0000_3530, 0, 0);
		wb(1'b0, fixcode_pkg::ADR_TTYPE, 0, 32'h0000_FFFF, 32'h0000_3530);
		wb(1'b0, fixcode_pkg::ADR_FIXRD, 0, 32'hFFFF_FFFF, 32'h1357_9BDF);
		for (int b = 0; b < 3; b++) cmd(fixcode_pkg::TYPE_COMPAT, 16'h0007, f2code(b), 1'b1,
			b == 0 ? 8'h00 : 8'h03);
		cmd(fixcode_pkg::TYPE_COMPAT, 16'h0005, f2code(0), 1'b1, 8'h02);
		for (int k = 0; k < 4; k++) begin
			lat = 4'h1 + 4'($random(seed) & 7);
			cmd(fixcode_pkg::TYPE_COMPAT, 16'h0007, f2code(0), 1'b1, 8'h00);
		end
		wb(1'b1, fixcode_pkg::ADR_TTYPE, 32'h0000_0000, 0, 0);
		wb(1'b0, fixcode_pkg::ADR_FIXRD, 0, 32'hFFFF_FFFF, 32'h2468_ACE0);
		// Mid-run reset must clear the selection and restart the reply counter
		wb(1'b1, fixcode_pkg::ADR_TTYPE, 32'h0000_3530, 0, 0);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rcnt = 8'h00;
		wb(1'b0, fixcode_pkg::ADR_TTYPE, 0, 32'h0000_FFFF, 32'h0000_0000);
		wb(1'b0, fixcode_pkg::ADR_STAT, 0, 32'h0000_FF03, 32'h0000_0000);
		cmd(fixcode_pkg::TYPE_LOCK, 16'h0005, {24'h0, 40'($random(seed))}, 1'b1, 8'h00);
		repeat (4) @(posedge clk_i);
		cmp_val(70'(rdq.size() + tagq.size()), 70'h0);
		test_done();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		test_done();
	end
endmodule // fixcode_cmd_tb
